// *** hdl/logger_map.svh ***
// register indexes, bit positions and fixed values of the logger control block
// assumes byte address = index * 4 on the register bus
`ifndef LOGGER_MAP_SVH
`define LOGGER_MAP_SVH

`define IDX_LOW_THR      14'h0208
`define IDX_HIGH_THR     14'h0209
`define IDX_SENSOR       14'h0210
`define IDX_OSC          14'h0212
`define IDX_MISSION      14'h0213
`define IDX_ALARM        14'h0214
`define IDX_STATE        14'h0215

`define BIT_LO_EN        0
`define BIT_HI_EN        1
`define BIT_OSC_RUN      0
`define BIT_FAST         1
`define BIT_LOG_EN       0
`define BIT_WIDE         2
`define BIT_WRAP         4
`define BIT_ALARM_TRIGGERED_START         5
`define MISSION_LOW      0
`define MISSION_HIGH     5

`define MISSION_ONES     8'hc0
`define ALARM_ONES       8'h70
`define STATE_ONES       8'hc0
`define BIT_LOW_FLAG     0
`define BIT_HIGH_FLAG    1
`define BIT_BATT         7
`define BIT_MIP          1
`define BIT_WIPED        3
`define BIT_AWAIT        4

`define THR_RESET        8'h00
`define LOG_BASE         16'h1000
`define LOG_BYTES        14'h2000
`define LOG_STEP_NARROW  14'h0001
`define LOG_STEP_WIDE    14'h0002
`define RESP_OKAY        2'b00
`define RESP_DECERR      2'b11

`endif

// *** hdl/logger_pkg.sv ***
// types shared by the logger control block
// assumes nothing of its surroundings
package logger_pkg;
   typedef enum logic [1:0] {
      MS_IDLE,
      MS_WAIT_ALARM,
      MS_LOGGING,
      MS_FULL
   } mission_e;
   typedef logic [7:0]  byte_t;
   typedef logic [12:0] log_off_t;
endpackage

// *** hdl/log_if.sv ***
// carrier between mission control and the log pointer
// assumes one clock for both ends
`timescale 1ns/100ps
interface log_if;
   logic                     step;
   logic                     wide;
   logic                     wrap;
   logic                     restart;
   logger_pkg::log_off_t     offset;
   logic                     full;
   modport ctrl  (output step, output wide, output wrap, output restart,
                  input offset, input full);
   modport store (input step, input wide, input wrap, input restart,
                  output offset, output full);
endinterface

// *** hdl/log_pointer.sv ***
// log write pointer over the data-log area
// assumes step only while not full
`timescale 1ns/100ps
`include "logger_map.svh"
module log_pointer (
   input  wire logic clk_in,
   input  wire logic nrst_in,
   log_if.store      lg
);
   import logger_pkg::*;
   logic [13:0] offset_r;
   logic        full_r;
   logic [13:0] sum;

   assign sum       = offset_r + (lg.wide ? `LOG_STEP_WIDE : `LOG_STEP_NARROW);
   assign lg.offset = offset_r[12:0];
   assign lg.full   = full_r;

   always_ff @(posedge clk_in) begin
      if (!nrst_in || lg.restart) begin
         offset_r <= 14'h0000;
         full_r   <= 1'b0;
      end else if (lg.step && !full_r) begin
         if (sum >= `LOG_BYTES) begin
            if (lg.wrap) begin
               offset_r <= 14'h0000;
            end else begin
               full_r <= 1'b1;
            end
         end else begin
            offset_r <= sum;
         end
      end
   end
endmodule

// *** hdl/alarm_compare.sv ***
// threshold compare on the result msb
// assumes thresholds and enables are stable registers
`timescale 1ns/100ps
module alarm_compare (
   input  wire logic               hi_en_in,
   input  wire logic               lo_en_in,
   input  wire logger_pkg::byte_t  high_thr_in,
   input  wire logger_pkg::byte_t  low_thr_in,
   input  wire logic [15:0]        result_in,
   output logic                    high_hit_out,
   output logic                    low_hit_out
);
   import logger_pkg::*;
   assign high_hit_out = hi_en_in && (result_in[15:8] >= high_thr_in);
   assign low_hit_out  = lo_en_in && (result_in[15:8] <= low_thr_in);
endmodule

// *** hdl/logger_ctrl.sv ***
// mission, alarm and oscillator control registers of a temperature logger
// assumes command pulses and conversion results come from the command logic
//
// What this block does
// - mission running: sensor, oscillator and mission setup writes are dropped
// - sensor and oscillator registers: bits 2 to 7 read 0, not writable
// - one-byte low and high alarm threshold registers
// - high alarm flag set when enabled and result msb at or above high threshold
// - low alarm flag set when enabled and result msb at or below low threshold
// - fast_sample_units: 0 rate in minutes, 1 rate in seconds
// - oscillator_run 1 starts oscillator, 0 stops it into retention mode
// - forced conversion or start mission sets oscillator_run
// - mission setup bits 7 and 6 read 1, not writable to 0
// - alarm-triggered start: 8-bit conversions, logging begins with alarming sample
// - the triggering conversion does not advance the mission sample counter
// - wrap enabled: full log restarts at first log address
// - wrap disabled: full log stops conversions, mission stays active
// - wide format stores two bytes, msb at lower address
// - log_enable needed for a mission, samples start at first log address
// - alarm status read only, bits 4-6 read 1, bits 2-3 read 0
// - clear memory clears the high and low alarm flags together, battery reset flag kept
// - battery reset flag set by power-on reset, always enabled
// - general status read only with awaiting, wiped and active bits
// - forced conversions and the triggering alarm also set flags
// - only the msb of a result is compared
// - awaiting_alarm set by alarm start, cleared by alarm, kept by clear memory
// - memory_wiped set by clear memory, cleared by start, start needs it
// - mission_active high while a mission runs, low after it ends
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "logger_map.svh"
module logger_ctrl (
   input  wire logic               clk_in,
   input  wire logic               nrst_in,
   // register bus
   input  wire logic [15:0]        s_axi_awaddr_in,
   input  wire logic               s_axi_awvalid_in,
   output logic                    s_axi_awready_out,
   input  wire logic [31:0]        s_axi_wdata_in,
   input  wire logic [3:0]         s_axi_wstrb_in,
   input  wire logic               s_axi_wvalid_in,
   output logic                    s_axi_wready_out,
   output logic [1:0]              s_axi_bresp_out,
   output logic                    s_axi_bvalid_out,
   input  wire logic               s_axi_bready_in,
   input  wire logic [15:0]        s_axi_araddr_in,
   input  wire logic               s_axi_arvalid_in,
   output logic                    s_axi_arready_out,
   output logic [31:0]             s_axi_rdata_out,
   output logic [1:0]              s_axi_rresp_out,
   output logic                    s_axi_rvalid_out,
   input  wire logic               s_axi_rready_in,
   // commands from the command logic
   input  wire logic               force_conv_in,
   input  wire logic               start_mission_in,
   input  wire logic               stop_mission_in,
   input  wire logic               clear_mem_in,
   // conversion results
   input  wire logic               conv_valid_in,
   input  wire logic [15:0]        conv_data_in,
   // control towards clock, sensor and log memory
   output logic                    osc_run_out,
   output logic                    fast_units_out,
   output logic                    conv_allow_out,
   output logic                    conv_narrow_out,
   output logic                    sample_inc_out,
   output logic                    mission_active_out,
   output logic                    log_we_out,
   output logic                    log_wide_out,
   output logic [15:0]             log_addr_out,
   output logic [15:0]             log_data_out
);
   import logger_pkg::*;

   mission_e     state_r;
   byte_t        low_thr_r;
   byte_t        high_thr_r;
   logic         hi_en_r;
   logic         lo_en_r;
   logic         osc_run_r;
   logic         fast_r;
   logic [5:0]   mission_cfg_r;
   logic         hi_flag_r;
   logic         lo_flag_r;
   logic         batt_r;
   logic         await_r;
   logic         wiped_r;
   logic         log_we_r;
   logic         log_wide_r;
   logic [15:0]  log_addr_r;
   logic [15:0]  log_data_r;
   logic         sample_inc_r;

   // bus slave state
   logic         aw_held_r;
   logic [15:0]  aw_addr_r;
   logic         w_held_r;
   logic [31:0]  w_data_r;
   logic [3:0]   w_strb_r;
   logic         bvalid_r;
   logic [1:0]   bresp_r;
   logic         rvalid_r;
   logic [1:0]   rresp_r;
   logic [31:0]  rdata_r;

   logic         locked;
   logic         do_write;
   logic         wr_byte;
   logic [13:0]  wr_idx;
   logic         wr_hit;
   logic [7:0]   wr_val;
   logic [13:0]  rd_idx;
   logic         rd_hit;
   byte_t        rd_val;
   logic         high_hit;
   logic         low_hit;
   logic         any_hit;
   logic         conv_live;
   logic         log_now;
   logic         start_ok;
   logic         clear_ok;
   logic         wide_sel;
   logic         wrap_sel;
   logic         alarm_triggered_start_sel;

   log_if lg ();

   alarm_compare u_cmp (
      .hi_en_in     (hi_en_r),
      .lo_en_in     (lo_en_r),
      .high_thr_in  (high_thr_r),
      .low_thr_in   (low_thr_r),
      .result_in    (conv_data_in),
      .high_hit_out (high_hit),
      .low_hit_out  (low_hit)
   );

   log_pointer u_ptr (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .lg      (lg)
   );

   assign wide_sel  = mission_cfg_r[`BIT_WIDE];
   assign wrap_sel  = mission_cfg_r[`BIT_WRAP];
   assign alarm_triggered_start_sel  = mission_cfg_r[`BIT_ALARM_TRIGGERED_START];
   assign locked    = (state_r != MS_IDLE);
   assign any_hit   = high_hit || low_hit;
   assign start_ok  = start_mission_in && !locked && wiped_r
                      && mission_cfg_r[`BIT_LOG_EN];
   assign clear_ok  = clear_mem_in && !locked;
   // conversions are ignored once a full log has stopped them
   assign conv_live = conv_valid_in && (state_r != MS_FULL);
   assign log_now   = conv_valid_in && ((state_r == MS_LOGGING)
                      || ((state_r == MS_WAIT_ALARM) && any_hit));

   assign lg.step    = log_now;
   assign lg.wide    = wide_sel;
   assign lg.wrap    = wrap_sel;
   assign lg.restart = start_ok;

   // ---------------- register bus slave ----------------
   assign s_axi_awready_out = !aw_held_r;
   assign s_axi_wready_out  = !w_held_r;
   assign s_axi_bvalid_out  = bvalid_r;
   assign s_axi_bresp_out   = bresp_r;
   assign s_axi_arready_out = !rvalid_r;
   assign s_axi_rvalid_out  = rvalid_r;
   assign s_axi_rresp_out   = rresp_r;
   assign s_axi_rdata_out   = rdata_r;

   assign do_write = aw_held_r && w_held_r && !bvalid_r;
   assign wr_idx   = aw_addr_r[15:2];
   assign wr_byte  = do_write && w_strb_r[0];
   assign wr_val   = w_data_r[7:0];
   assign rd_idx   = s_axi_araddr_in[15:2];

   always_comb begin
      wr_hit = 1'b1;
      unique case (wr_idx)
         `IDX_LOW_THR, `IDX_HIGH_THR, `IDX_SENSOR, `IDX_OSC,
         `IDX_MISSION, `IDX_ALARM, `IDX_STATE: wr_hit = (aw_addr_r[1:0] == 2'b00);
         default: wr_hit = 1'b0;
      endcase
   end

   always_comb begin
      rd_hit = s_axi_araddr_in[1:0] == 2'b00;
      rd_val = 8'h00;
      unique case (rd_idx)
         `IDX_LOW_THR:  rd_val = low_thr_r;
         `IDX_HIGH_THR: rd_val = high_thr_r;
         `IDX_SENSOR:   rd_val = {6'h00, hi_en_r, lo_en_r};
         `IDX_OSC:      rd_val = {6'h00, fast_r, osc_run_r};
         `IDX_MISSION:  rd_val = `MISSION_ONES | {2'b00, mission_cfg_r};
         `IDX_ALARM:    rd_val = `ALARM_ONES | {batt_r, 5'h00, hi_flag_r, lo_flag_r};
         `IDX_STATE:    rd_val = `STATE_ONES | {3'h0, await_r, wiped_r, 1'b0,
                                                locked, 1'b0};
         default:       rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 16'h0000;
      end else if (s_axi_awvalid_in && !aw_held_r) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr_in;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid_in && !w_held_r) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata_in;
         w_strb_r <= s_axi_wstrb_in;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_bready_in) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         rvalid_r <= 1'b0;
         rresp_r  <= `RESP_OKAY;
         rdata_r  <= 32'h0000_0000;
      end else if (s_axi_arvalid_in && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r  <= rd_hit ? `RESP_OKAY : `RESP_DECERR;
         rdata_r  <= rd_hit ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end else if (s_axi_rready_in) begin
         rvalid_r <= 1'b0;
      end
   end

   // ---------------- configuration registers ----------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         low_thr_r  <= `THR_RESET;
         high_thr_r <= `THR_RESET;
      end else if (wr_byte && wr_hit && !locked) begin
         if (wr_idx == `IDX_LOW_THR) begin
            low_thr_r <= wr_val;
         end
         if (wr_idx == `IDX_HIGH_THR) begin
            high_thr_r <= wr_val;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         hi_en_r <= 1'b0;
         lo_en_r <= 1'b0;
      end else if (wr_byte && (wr_idx == `IDX_SENSOR) && wr_hit && !locked) begin
         hi_en_r <= wr_val[`BIT_HI_EN];
         lo_en_r <= wr_val[`BIT_LO_EN];
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         osc_run_r <= 1'b0;
         fast_r    <= 1'b0;
      end else begin
         if (wr_byte && (wr_idx == `IDX_OSC) && wr_hit && !locked) begin
            osc_run_r <= wr_val[`BIT_OSC_RUN];
            fast_r    <= wr_val[`BIT_FAST];
         end
         if (force_conv_in || start_ok) begin
            osc_run_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         mission_cfg_r <= 6'h00;
      end else if (wr_byte && (wr_idx == `IDX_MISSION) && wr_hit && !locked) begin
         // bits 1 and 3 are kept for read-back only
         mission_cfg_r <= wr_val[`MISSION_HIGH:`MISSION_LOW];
      end
   end

   // ---------------- status flags ----------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         hi_flag_r <= 1'b0;
         lo_flag_r <= 1'b0;
      end else begin
         if (clear_ok) begin
            hi_flag_r <= 1'b0;
            lo_flag_r <= 1'b0;
         end
         // set wins over clear; flags stay until cleared
         if (conv_live && high_hit) begin
            hi_flag_r <= 1'b1;
         end
         if (conv_live && low_hit) begin
            lo_flag_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         batt_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         await_r <= 1'b0;
      end else if (start_ok) begin
         await_r <= alarm_triggered_start_sel;
      end else if (conv_live && any_hit) begin
         await_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wiped_r <= 1'b0;
      end else if (clear_ok) begin
         wiped_r <= 1'b1;
      end else if (start_ok) begin
         wiped_r <= 1'b0;
      end
   end

   // ---------------- mission sequence ----------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_r <= MS_IDLE;
      end else if (stop_mission_in) begin
         state_r <= MS_IDLE;
      end else begin
         unique case (state_r)
            MS_IDLE: begin
               if (start_ok) begin
                  state_r <= alarm_triggered_start_sel ? MS_WAIT_ALARM : MS_LOGGING;
               end
            end
            MS_WAIT_ALARM: begin
               if (conv_valid_in && any_hit) begin
                  state_r <= MS_LOGGING;
               end
            end
            MS_LOGGING: begin
               if (lg.full) begin
                  state_r <= MS_FULL;
               end
            end
            MS_FULL: begin
               state_r <= MS_FULL;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         log_we_r     <= 1'b0;
         log_wide_r   <= 1'b0;
         log_addr_r   <= `LOG_BASE;
         log_data_r   <= 16'h0000;
         sample_inc_r <= 1'b0;
      end else begin
         log_we_r     <= log_now && !lg.full;
         sample_inc_r <= conv_valid_in && (state_r == MS_LOGGING) && !lg.full;
         if (log_now) begin
            log_wide_r <= wide_sel;
            log_addr_r <= `LOG_BASE + {3'b000, lg.offset};
            // msb first: it lands at the lower address
            log_data_r <= wide_sel ? conv_data_in
                                   : {conv_data_in[15:8], 8'h00};
         end
      end
   end

   assign osc_run_out        = osc_run_r;
   assign fast_units_out     = fast_r;
   assign mission_active_out = locked;
   assign conv_allow_out     = (state_r == MS_WAIT_ALARM) || (state_r == MS_LOGGING);
   assign conv_narrow_out    = (state_r == MS_WAIT_ALARM);
   assign sample_inc_out     = sample_inc_r;
   assign log_we_out         = log_we_r;
   assign log_wide_out       = log_wide_r;
   assign log_addr_out       = log_addr_r;
   assign log_data_out       = log_data_r;
endmodule

// *** verification/logger_ctrl_chk.sv ***
// port assertions for the logger control block
// assumes one clock and a synchronous active low reset
`timescale 1ns/100ps
module logger_ctrl_chk (
   input wire logic        clk_in,
   input wire logic        nrst_in,
   input wire logic        force_conv_in,
   input wire logic        start_mission_in,
   input wire logic        stop_mission_in,
   input wire logic        conv_valid_in,
   input wire logic [15:0] conv_data_in,
   input wire logic        osc_run_out,
   input wire logic        conv_allow_out,
   input wire logic        conv_narrow_out,
   input wire logic        sample_inc_out,
   input wire logic        mission_active_out,
   input wire logic        log_we_out,
   input wire logic        log_wide_out,
   input wire logic [15:0] log_addr_out,
   input wire logic [15:0] log_data_out,
   input wire logic        s_axi_rvalid_out,
   input wire logic [31:0] s_axi_rdata_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_force_osc_on:
      assert property (force_conv_in |=> osc_run_out)
      else $error("forced conversion left oscillator off");
   a_start_osc_on:
      assert property (start_mission_in && !mission_active_out ##1 mission_active_out
                       |-> osc_run_out)
      else $error("mission started with oscillator off");
   a_stop_ends_mission:
      assert property (stop_mission_in |=> !mission_active_out && !conv_allow_out)
      else $error("mission still active after stop");
   a_idle_no_conv:
      assert property (!mission_active_out |-> !conv_allow_out && !conv_narrow_out)
      else $error("conversions requested while idle");
   a_inc_cause:
      assert property (sample_inc_out |-> $past(conv_valid_in) && log_we_out)
      else $error("sample count advanced without a logged conversion");
   a_log_in_area:
      assert property (log_we_out |-> log_addr_out >= 16'h1000 && log_addr_out < 16'h3000)
      else $error("log write outside the log area");
   a_wide_data:
      assert property (log_we_out && log_wide_out |-> log_data_out == $past(conv_data_in))
      else $error("wide sample data differs from result");
   a_read_byte:
      assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
      else $error("read data upper bits not zero");
endmodule
bind logger_ctrl logger_ctrl_chk chk_u (.clk_in, .nrst_in, .force_conv_in, .start_mission_in,
   .stop_mission_in, .conv_valid_in, .conv_data_in, .osc_run_out, .conv_allow_out,
   .conv_narrow_out, .sample_inc_out, .mission_active_out, .log_we_out, .log_wide_out,
   .log_addr_out, .log_data_out, .s_axi_rvalid_out, .s_axi_rdata_out);

// *** verification/log_mem_model.sv ***
// byte-wide log memory behind the log write port
// assumes one write pulse per sample, two bytes in wide format
`timescale 1ns/100ps
module log_mem_model (
   input  wire logic        clk_in,
   input  wire logic        we_in,
   input  wire logic        wide_in,
   input  wire logic [15:0] addr_in,
   input  wire logic [15:0] data_in,
   output int               count_out,
   output logic [15:0]      last_out
);
   logic [7:0] mem [0:16'h3fff];
   initial count_out = 0;
   initial last_out = 16'h0000;
   always @(posedge clk_in) begin
      if (we_in === 1'b1) begin
         count_out <= count_out + 1;
         last_out <= addr_in;
         mem[addr_in[13:0]] <= data_in[15:8];
         if (wide_in === 1'b1) begin
            mem[addr_in[13:0] + 14'h0001] <= data_in[7:0];
         end
      end
   end
endmodule

// *** verification/logger_ctrl_tb.sv ***
// self-checking bench for the logger control block
// assumes the log memory model and the port checker
`timescale 1ns/100ps
`include "logger_map.svh"
module logger_ctrl_tb;
   typedef struct packed {
      logic [15:0] a;
      logic [7:0]  w;
      logic [7:0]  e;
      logic [1:0]  r;
   } row_s;
   localparam logic [1:0] OK = `RESP_OKAY;
   localparam logic [1:0] DE = `RESP_DECERR;
   logic        clk_in, nrst_in, aw_v, w_v, b_r, ar_v, r_r, cv;
   logic [15:0] aw_a, ar_a, cd;
   logic [7:0]  w_d;
   logic [3:0]  cmd;
   wire logic   aw_rdy, w_rdy, b_v, ar_rdy, r_v, osc, fast, allow, narrow, inc;
   wire logic   active, we, wide;
   wire logic [1:0]  b_resp, r_resp;
   wire logic [31:0] r_d;
   wire logic [15:0] la, ld, last;
   int          fails, comparisons, incs, cnt, n0, s0;
   row_s        rows [10] = '{
      '{16'h0850, 8'h00, 8'hf0, OK}, '{16'h0854, 8'hff, 8'hc0, OK},
      '{16'h0820, 8'h3e, 8'h3e, OK}, '{16'h0824, 8'h85, 8'h85, OK},
      '{16'h0840, 8'hff, 8'h03, OK}, '{16'h0848, 8'hfe, 8'h02, OK},
      '{16'h084c, 8'h00, 8'hc0, OK}, '{16'h084c, 8'h35, 8'hf5, OK},
      '{16'h0858, 8'h12, 8'h00, DE}, '{16'h0821, 8'h12, 8'h00, DE}};
   logger_ctrl dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_rdy),
      .s_axi_wdata_in({24'h0, w_d}), .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(w_v),
      .s_axi_wready_out(w_rdy), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_v),
      .s_axi_bready_in(b_r), .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v),
      .s_axi_arready_out(ar_rdy), .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_resp),
      .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r), .force_conv_in(cmd[0]),
      .start_mission_in(cmd[1]), .stop_mission_in(cmd[2]), .clear_mem_in(cmd[3]),
      .conv_valid_in(cv), .conv_data_in(cd), .osc_run_out(osc), .fast_units_out(fast),
      .conv_allow_out(allow), .conv_narrow_out(narrow), .sample_inc_out(inc),
      .mission_active_out(active), .log_we_out(we), .log_wide_out(wide),
      .log_addr_out(la), .log_data_out(ld));
   log_mem_model mem_u (.clk_in(clk_in), .we_in(we), .wide_in(wide), .addr_in(la),
      .data_in(ld), .count_out(cnt), .last_out(last));
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      if (inc === 1'b1) incs <= incs + 1;
   end
   task final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tmo;
      fails++;
      $display("CHECK FAILED %0t no bus answer", $time);
      final_report;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      int   n;
      logic ao, wo;
      @(posedge clk_in);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      b_r <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge clk_in);
         if (b_v === 1'b1 && !aw_v && !w_v) break;
         ao = aw_v && aw_rdy === 1'b1;
         wo = w_v && w_rdy === 1'b1;
         @(posedge clk_in);
         if (ao) aw_v <= 1'b0;
         if (wo) w_v <= 1'b0;
      end
      if (n == 100) tmo;
      chk({30'h0, b_resp}, {30'h0, er});
      @(posedge clk_in);
      b_r <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
      int   n;
      logic ao;
      @(posedge clk_in);
      ar_a <= a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(negedge clk_in);
         if (r_v === 1'b1 && !ar_v) break;
         ao = ar_v && ar_rdy === 1'b1;
         @(posedge clk_in);
         if (ao) ar_v <= 1'b0;
      end
      if (n == 100) tmo;
      chk({30'h0, r_resp}, {30'h0, er});
      chk(r_d, {24'h0, e});
      @(posedge clk_in);
      r_r <= 1'b0;
   endtask
   task automatic pulse(input logic [3:0] m);
      @(posedge clk_in);
      cmd <= m;
      @(posedge clk_in);
      cmd <= 4'h0;
   endtask
   task automatic fill(input logic [15:0] d, input int k);
      @(posedge clk_in);
      cv <= 1'b1;
      cd <= d;
      repeat (k) @(posedge clk_in);
      cv <= 1'b0;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   initial begin
      {nrst_in, aw_v, w_v, b_r, ar_v, r_r, cv} = 7'h00;
      {aw_a, ar_a, cd, w_d, cmd} = 60'h0;
      {fails, comparisons, incs} = 96'h0;
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, rows[i].r);
         rd(rows[i].a, rows[i].e, rows[i].r);
      end
      chk({31'h0, osc}, 32'h0);
      chk({31'h0, fast}, 32'h1);
      wr(16'h084c, 8'h05, OK);
      pulse(4'h1);
      fill(16'h9000, 1);
      chk({31'h0, osc}, 32'h1);
      rd(16'h0850, 8'hf2, OK);
      pulse(4'h8);
      rd(16'h0850, 8'hf0, OK);
      rd(16'h0854, 8'hc8, OK);
      pulse(4'h2);
      rd(16'h0854, 8'hc2, OK);
      wr(16'h0840, 8'h00, OK);
      rd(16'h0840, 8'h03, OK);
      fill(16'h5060, 1);
      chk({24'h0, mem_u.mem[14'h1000]}, 32'h50);
      chk({24'h0, mem_u.mem[14'h1001]}, 32'h60);
      fill(16'h20aa, 1);
      rd(16'h0850, 8'hf1, OK);
      fill(16'h5000, 1);
      rd(16'h0850, 8'hf1, OK);
      pulse(4'h4);
      rd(16'h0854, 8'hc0, OK);
      pulse(4'h8);
      wr(16'h084c, 8'h21, OK);
      pulse(4'h2);
      rd(16'h0854, 8'hd2, OK);
      chk({31'h0, narrow}, 32'h1);
      n0 = cnt;
      s0 = incs;
      fill(16'h5000, 1);
      chk(cnt, n0);
      fill(16'h3000, 1);
      chk(cnt, n0 + 1);
      chk({24'h0, mem_u.mem[14'h1000]}, 32'h30);
      chk(incs, s0);
      rd(16'h0854, 8'hc2, OK);
      rd(16'h0850, 8'hf1, OK);
      pulse(4'h4);
      pulse(4'h8);
      wr(16'h0840, 8'h00, OK);
      wr(16'h084c, 8'h11, OK);
      pulse(4'h2);
      fill(16'hff00, 8193);
      chk({16'h0, last}, 32'h1000);
      rd(16'h0850, 8'hf0, OK);
      pulse(4'h4);
      pulse(4'h8);
      wr(16'h084c, 8'h01, OK);
      pulse(4'h2);
      n0 = cnt;
      s0 = incs;
      fill(16'hff00, 8193);
      chk(cnt, n0 + 8192);
      chk(incs, s0 + 8192);
      chk({30'h0, allow, active}, 32'h1);
      pulse(4'h4);
      final_report;
   end
endmodule
